//--- core/sbtc_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the 16-bit timer/counter.
  Assumes inclusion by bare name from the core files; definitions only.
*/
`ifndef SBTC_CONSTS_SVH
`define SBTC_CONSTS_SVH

// ============================================================
// register byte addresses
`define SBTC_ADDR_COUNT_LOW    12'h000
`define SBTC_ADDR_COUNT_HIGH   12'h004
`define SBTC_ADDR_CONTROL      12'h008
`define SBTC_ADDR_FLAG         12'h00C
`define SBTC_ADDR_ENABLE       12'h010

// ============================================================
// counter_control field positions
`define SBTC_CTRL_WIDE         7
`define SBTC_CTRL_XSTAT        6
`define SBTC_CTRL_PRESC_HI     5
`define SBTC_CTRL_PRESC_LO     4
`define SBTC_CTRL_OSC_EN       3
`define SBTC_CTRL_NOSYNC       2
`define SBTC_CTRL_CLKSEL       1
`define SBTC_CTRL_RUN          0

// ============================================================
// flag and enable positions, reset values
`define SBTC_FLAG_OVF          0
`define SBTC_CTRL_RESET        8'h00
`define SBTC_COUNT_RESET       16'h0000
`define SBTC_COUNT_MAX         16'hFFFF

// ============================================================
// compare mode code and timing counts
`define SBTC_MODE_SPECIAL_TRIG 4'hB
`define SBTC_INSTR_CLOCKS      4
`define SBTC_INSTR_LAST        2'(`SBTC_INSTR_CLOCKS - 1)

`endif

//--- core/sbtc_pkg.sv
/*
  Types shared by the 16-bit timer/counter core.
  Assumes nothing of its surroundings.
*/
package sbtc_pkg;

  // ============================================================
  // counting modes
  typedef enum logic [1:0] {
    SBTC_MODE_TIMER,
    SBTC_MODE_SYNC_COUNT,
    SBTC_MODE_ASYNC_COUNT
  } sbtc_count_mode_t;

endpackage

//--- core/sbtc_edge_sync.sv
/*
  Two-stage synchronizer for a pin level, with edge detection behind it.
  Assumes the input is asynchronous to ref_clk and slower than half its rate.
*/
module sbtc_edge_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // pin side
  input  wire logic asyncIn,
  // synchronous side
  output logic      level,
  output logic      rise,
  output logic      fall
);

  // ============================================================
  // stages
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;

endmodule

//--- core/sbtc_timer_top.sv
/*
  16-bit timer/counter with prescaler, special event trigger clear and APB registers.
  Assumes an APB master on ref_clk, compare-unit triggers on ref_clk, and count pins
  asynchronous to ref_clk.
*/
`include "sbtc_consts.svh"

module sbtc_timer_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // count pins
  input  wire logic        extCountIn,
  input  wire logic        crystalIn,
  input  wire logic        sysClkFromCrystal,
  // compare units
  input  wire logic [3:0]  compareAMode,
  input  wire logic        compareATrig,
  input  wire logic [3:0]  compareBMode,
  input  wire logic        compareBTrig,
  // outputs to the system
  output logic             crystalOscEnable,
  output logic             overflowIrq,
  output logic      [15:0] countValue
);

  // ============================================================
  // functions
  function automatic logic [2:0] prescaleLast(input logic [1:0] sel);
    return 3'((4'h1 << sel) - 4'h1);
  endfunction

  function automatic logic isSpecialTrig(input logic [3:0] mode, input logic trig);
    return trig && (mode == `SBTC_MODE_SPECIAL_TRIG);
  endfunction

  // ============================================================
  // state
  logic [15:0] count;
  logic [7:0]  highBuf;
  logic [7:0]  snapHigh;
  logic [6:0]  control;
  logic        overflowFlag;
  logic        overflowEnable;
  logic [2:0]  prescale;
  logic [1:0]  instrDiv;
  logic        armed;

  // ============================================================
  // pin synchronizers
  logic extLevel, extRise, extFall;
  logic xtalLevel, xtalRise, xtalFall;
  logic xstatLevel;

  // external count clock crosses two stages before any edge logic
  sbtc_edge_sync u_ext_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (extCountIn),
    .level   (extLevel),
    .rise    (extRise),
    .fall    (extFall)
  );

  sbtc_edge_sync u_xtal_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (crystalIn),
    .level   (xtalLevel),
    .rise    (xtalRise),
    .fall    (xtalFall)
  );

  sbtc_edge_sync u_xstat_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (sysClkFromCrystal),
    .level   (xstatLevel),
    .rise    (),
    .fall    ()
  );

  // ============================================================
  // control decode
  logic                      wideMode;
  logic [1:0]                prescaleSel;
  logic                      oscEnable;
  logic                      noSync;
  logic                      clockSelect;
  logic                      counterRun;
  sbtc_pkg::sbtc_count_mode_t countMode;

  assign wideMode    = control[`SBTC_CTRL_WIDE - 1];
  assign prescaleSel = control[`SBTC_CTRL_PRESC_HI:`SBTC_CTRL_PRESC_LO];
  assign oscEnable   = control[`SBTC_CTRL_OSC_EN];
  assign noSync      = control[`SBTC_CTRL_NOSYNC];
  assign clockSelect = control[`SBTC_CTRL_CLKSEL];
  assign counterRun  = control[`SBTC_CTRL_RUN];
  assign countMode   = !clockSelect ? sbtc_pkg::SBTC_MODE_TIMER :
                       noSync       ? sbtc_pkg::SBTC_MODE_ASYNC_COUNT :
                                      sbtc_pkg::SBTC_MODE_SYNC_COUNT;

  // ============================================================
  // apb decode
  logic setupPhase;
  logic accessDone;
  logic hitLow, hitHigh, hitControl, hitFlag, hitEnable;
  logic mapped;
  logic writeLow, writeHigh, writeControl, writeFlag, writeEnable;
  logic readLow;
  logic countWrite;

  assign setupPhase   = psel & ~penable;
  assign accessDone   = psel & penable;
  assign hitLow       = (paddr == `SBTC_ADDR_COUNT_LOW);
  assign hitHigh      = (paddr == `SBTC_ADDR_COUNT_HIGH);
  assign hitControl   = (paddr == `SBTC_ADDR_CONTROL);
  assign hitFlag      = (paddr == `SBTC_ADDR_FLAG);
  assign hitEnable    = (paddr == `SBTC_ADDR_ENABLE);
  assign mapped       = hitLow | hitHigh | hitControl | hitFlag | hitEnable;
  assign writeLow     = accessDone & pwrite & hitLow;
  assign writeHigh    = accessDone & pwrite & hitHigh;
  assign writeControl = accessDone & pwrite & hitControl;
  assign writeFlag    = accessDone & pwrite & hitFlag;
  assign writeEnable  = accessDone & pwrite & hitEnable;
  assign readLow      = accessDone & ~pwrite & hitLow;
  // in wide mode the high byte address only reaches the buffer
  assign countWrite   = writeLow | (writeHigh & ~wideMode);

  assign pready  = 1'b1;
  assign pslverr = accessDone & ~mapped;

  // ============================================================
  // read data, captured in the setup cycle
  logic [7:0]  readHighValue;
  logic [7:0]  readControl;
  logic [31:0] next_prdata;

  // live high byte directly, or the buffer in wide mode
  assign readHighValue = wideMode ? highBuf : count[15:8];
  assign readControl   = {control[6], xstatLevel, control[5:0]};
  assign next_prdata   = hitLow     ? {24'h00_0000, count[7:0]} :
                         hitHigh    ? {24'h00_0000, readHighValue} :
                         hitControl ? {24'h00_0000, readControl} :
                         hitFlag    ? {31'h0000_0000, overflowFlag} :
                         hitEnable  ? {31'h0000_0000, overflowEnable} :
                                      32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata   <= 32'h0000_0000;
      snapHigh <= 8'h00;
    end else if (setupPhase) begin
      prdata   <= next_prdata;
      snapHigh <= count[15:8];
    end
  end

  // ============================================================
  // count clock selection and prescaler
  logic instrTick;
  logic srcRise;
  logic srcFall;
  logic selectTick;
  logic incTick;

  assign instrTick  = (instrDiv == `SBTC_INSTR_LAST);
  assign srcRise    = oscEnable ? xtalRise : extRise;
  assign srcFall    = oscEnable ? xtalFall : extFall;
  // async counting only takes a rising edge once a falling edge has armed it
  assign selectTick = !clockSelect ? instrTick :
                      (srcRise & (armed | (countMode != sbtc_pkg::SBTC_MODE_ASYNC_COUNT)));
  // one increment per 8, 4, 2 or 1 selected ticks
  assign incTick    = counterRun & selectTick & (prescale == prescaleLast(prescaleSel));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      instrDiv <= 2'h0;
    end else begin
      instrDiv <= instrDiv + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= 3'h0;
    end else if (writeLow) begin
      prescale <= 3'h0;
    end else if (counterRun & selectTick) begin
      prescale <= incTick ? 3'h0 : prescale + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (countWrite) begin
      armed <= 1'b0;
    end else if (srcFall) begin
      armed <= 1'b1;
    end
  end

  // ============================================================
  // trigger clear and next count
  logic        trigClear;
  logic        wrap;
  logic [15:0] writtenCount;
  logic [15:0] next_count;

  // either compare unit in special-trigger mode clears, except in async counting
  assign trigClear    = (isSpecialTrig(compareAMode, compareATrig) | isSpecialTrig(compareBMode, compareBTrig))
                        & (countMode != sbtc_pkg::SBTC_MODE_ASYNC_COUNT);
  assign wrap         = incTick & (count == `SBTC_COUNT_MAX);
  assign writtenCount = writeLow ? {(wideMode ? highBuf : count[15:8]), pwdata[7:0]} :
                                   {pwdata[7:0], count[7:0]};
  // a write wins over a clear, a clear over counting, so the compare value is the period
  assign next_count   = countWrite ? writtenCount :
                        trigClear  ? `SBTC_COUNT_RESET :
                        incTick    ? count + 16'h0001 :
                                     count;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= `SBTC_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      highBuf <= 8'h00;
    end else if (writeHigh & wideMode) begin
      highBuf <= pwdata[7:0];
    end else if (readLow & wideMode) begin
      highBuf <= snapHigh;
    end
  end

  // ============================================================
  // control, flag and enable registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= 7'(`SBTC_CTRL_RESET);
    end else if (writeControl) begin
      control <= {pwdata[7], pwdata[5:0]};
    end
  end

  // a wrap or a write of 1 sets the flag; a trigger clear never does; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflowFlag <= 1'b0;
    end else if (wrap & ~countWrite & ~trigClear) begin
      overflowFlag <= 1'b1;
    end else if (writeFlag) begin
      overflowFlag <= pwdata[`SBTC_FLAG_OVF];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflowEnable <= 1'b0;
    end else if (writeEnable) begin
      overflowEnable <= pwdata[`SBTC_FLAG_OVF];
    end
  end

  assign overflowIrq      = overflowFlag & overflowEnable;
  assign crystalOscEnable = oscEnable;
  assign countValue       = count;

  // ============================================================
  // assertions
  property p_trig_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    (trigClear & ~countWrite) |=> (count == 16'h0000);
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear count");

  property p_async_no_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    ((countMode == sbtc_pkg::SBTC_MODE_ASYNC_COUNT) & ~countWrite & ~incTick
      & (isSpecialTrig(compareAMode, compareATrig) | isSpecialTrig(compareBMode, compareBTrig)))
      |=> (count == $past(count));
  endproperty
  a_async_no_clear: assert property (p_async_no_clear) else $error("clear active in async mode");

  property p_write_wins;
    @(posedge ref_clk) disable iff (!rst_b)
    (writeLow & trigClear) |=> (count[7:0] == $past(pwdata[7:0]));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("clear beat a software write");

  property p_flag_from_wrap;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(overflowFlag) |-> ($past(count) == 16'hFFFF || $past(writeFlag));
  endproperty
  a_flag_from_wrap: assert property (p_flag_from_wrap) else $error("flag set without wrap");

  property p_wrap_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    (wrap & ~countWrite & ~trigClear) |=> (count == 16'h0000) && overflowFlag;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap did not reach zero with flag");

  property p_instr_rate;
    @(posedge ref_clk) disable iff (!rst_b)
    instrTick |=> !instrTick [*3] ##1 instrTick;
  endproperty
  a_instr_rate: assert property (p_instr_rate) else $error("instruction tick not every 4 clocks");

  property p_count_cause;
    @(posedge ref_clk) disable iff (!rst_b)
    ##1 (count != $past(count)) |-> $past(countWrite | trigClear | incTick);
  endproperty
  a_count_cause: assert property (p_count_cause) else $error("count moved without cause");

  property p_wide_buffer;
    @(posedge ref_clk) disable iff (!rst_b)
    (readLow & wideMode & ~writeHigh) |=> (highBuf == $past(snapHigh));
  endproperty
  a_wide_buffer: assert property (p_wide_buffer) else $error("high buffer not loaded on low read");

  property p_async_rearm;
    @(posedge ref_clk) disable iff (!rst_b)
    countWrite |=> !armed;
  endproperty
  a_async_rearm: assert property (p_async_rearm) else $error("write did not disarm counting");

  property p_high_write;
    @(posedge ref_clk) disable iff (!rst_b)
    (writeHigh & ~wideMode) |=> (count[15:8] == $past(pwdata[7:0]));
  endproperty
  a_high_write: assert property (p_high_write) else $error("high byte write lost");

endmodule

//--- verif/sbtc_partner_model.sv
/*
  Far-side model: count pin source and the two compare units.
  Assumes the bench's ref_clk and rst_b; the pin clock is made from ref_clk counts.
*/
module sbtc_partner_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // bench control
  input  wire logic        pinRun,
  input  wire logic        useXtal,
  input  wire logic        manualEn,
  input  wire logic        manualLevel,
  input  wire logic [15:0] cmpValue,
  input  wire logic        pulseB,
  // device side
  input  wire logic [15:0] countValue,
  output logic             extCountIn,
  output logic             crystalIn,
  output logic             compareATrig,
  output logic             compareBTrig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pinClk;
  logic [3:0] halfCnt;
  logic       matchSeen;
  logic       matchPulse;
  logic       pinLevel;
  // ============================================================
  // pin source and trigger outputs
  assign pinLevel     = manualEn ? manualLevel : pinClk;
  assign extCountIn   = useXtal ? 1'b0 : pinLevel;
  assign crystalIn    = useXtal ? pinLevel : 1'b0;  // oscillator pin held low unless useXtal
  assign compareATrig = matchPulse;
  assign compareBTrig = matchPulse | pulseB;
  // ============================================================
  // pin clock stands still while not run; one pulse per match
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinClk     <= 1'b0;
      halfCnt    <= 4'h0;
      matchSeen  <= 1'b0;
      matchPulse <= 1'b0;
    end else begin
      matchSeen  <= countValue == cmpValue;
      matchPulse <= (countValue == cmpValue) && !matchSeen;
      if (!pinRun) begin
        halfCnt <= 4'h0;
      end else if (halfCnt == 4'h9) begin
        halfCnt <= 4'h0;
        pinClk  <= !pinClk;
      end else begin
        halfCnt <= halfCnt + 4'h1;
      end
    end
  end
endmodule

//--- verif/sbtc_timer_top_tb.sv
/*
  Self-checking bench for the 16-bit timer/counter: APB master tasks and scenarios.
  Assumes the core files and the far-side model are compiled first.
*/
`include "sbtc_consts.svh"
module sbtc_timer_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        extCountIn, crystalIn, sysClkFromCrystal, compareATrig, compareBTrig;
  logic [3:0]  compareAMode, compareBMode;
  logic        crystalOscEnable, overflowIrq, err;
  logic [15:0] countValue, cmpValue;
  logic        pinRun, useXtal, manualEn, manualLevel, pulseB;
  int          errorCnt = 0;
  int          cmpCount = 0;
  int          gap;

  sbtc_timer_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extCountIn(extCountIn), .crystalIn(crystalIn),
    .sysClkFromCrystal(sysClkFromCrystal), .compareAMode(compareAMode),
    .compareATrig(compareATrig), .compareBMode(compareBMode), .compareBTrig(compareBTrig),
    .crystalOscEnable(crystalOscEnable), .overflowIrq(overflowIrq), .countValue(countValue));
  sbtc_partner_model partner (.ref_clk(ref_clk), .rst_b(rst_b), .pinRun(pinRun),
    .useXtal(useXtal), .manualEn(manualEn), .manualLevel(manualLevel), .cmpValue(cmpValue),
    .pulseB(pulseB), .countValue(countValue), .extCountIn(extCountIn), .crystalIn(crystalIn),
    .compareATrig(compareATrig), .compareBTrig(compareBTrig));

  // ============================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; trig raises a unit B pulse in the access cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic trig);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    pulseB  <= trig;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pulseB  <= 1'b0;
    // one idle edge, so the next call never reassigns psel in this time step
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00, 1'b0);
    check(rd, exp);
  endtask
  task automatic waitFor(input logic [15:0] v, input int lim);
    int n;
    n = 0;
    while (countValue !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check(32'(countValue), 32'(v));
  endtask
  task automatic tickGap(output int g);
    logic [15:0] last;
    int n;
    n = 0;
    @(posedge ref_clk);
    last = countValue;
    while (countValue === last && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    last = countValue;
    g = 0;
    while (countValue === last && g < 400) begin
      @(posedge ref_clk);
      g++;
    end
  endtask

  // ============================================================
  // scenarios
  task automatic regScenario();
    rdChk(`SBTC_ADDR_CONTROL, 32'h0000_0000);
    rdChk(`SBTC_ADDR_COUNT_HIGH, 32'h0000_0000);
    wr(`SBTC_ADDR_CONTROL, 8'hFE);
    rdChk(`SBTC_ADDR_CONTROL, 32'h0000_00BE);
    check(32'(crystalOscEnable), 32'h0000_0001);
    sysClkFromCrystal <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdChk(`SBTC_ADDR_CONTROL, 32'h0000_00FE);
    wr(`SBTC_ADDR_CONTROL, 8'h00);
    apb(1'b1, 12'h014, 8'hAA, 1'b0);
    check(32'(err), 32'h0000_0001);
    rdChk(12'h014, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(32'(pready), 32'h0000_0001);
    wr(`SBTC_ADDR_COUNT_HIGH, 8'hA5);
    wr(`SBTC_ADDR_COUNT_LOW, 8'h5A);
    rdChk(`SBTC_ADDR_COUNT_LOW, 32'h0000_005A);
    rdChk(`SBTC_ADDR_COUNT_HIGH, 32'h0000_00A5);
  endtask
  task automatic prescaleScenario();
    for (int ps = 0; ps < 4; ps++) begin
      wr(`SBTC_ADDR_CONTROL, {2'b00, 2'(ps), 4'h1});
      tickGap(gap);
      check(32'(gap), 32'(4 << ps));
    end
    pinRun <= 1'b1;
    wr(`SBTC_ADDR_CONTROL, 8'h03);
    tickGap(gap);
    check(32'(gap), 32'h0000_0014);
    wr(`SBTC_ADDR_CONTROL, 8'h00);
  endtask
  task automatic overflowScenario();
    wr(`SBTC_ADDR_COUNT_HIGH, 8'hFF);
    wr(`SBTC_ADDR_COUNT_LOW, 8'hF0);
    wr(`SBTC_ADDR_CONTROL, 8'h01);
    waitFor(16'h0001, 200);
    check(32'(overflowIrq), 32'h0000_0000);
    rdChk(`SBTC_ADDR_FLAG, 32'h0000_0001);
    wr(`SBTC_ADDR_ENABLE, 8'h01);
    @(posedge ref_clk);
    check(32'(overflowIrq), 32'h0000_0001);
    wr(`SBTC_ADDR_FLAG, 8'h00);
    @(posedge ref_clk);
    check(32'(overflowIrq), 32'h0000_0000);
  endtask
  task automatic trigScenario();
    for (int u = 0; u < 3; u++) begin
      for (int m = 0; m < 2; m++) begin
        wr(`SBTC_ADDR_CONTROL, 8'h00);
        wr(`SBTC_ADDR_COUNT_HIGH, 8'h00);
        wr(`SBTC_ADDR_COUNT_LOW, 8'h00);
        compareAMode <= (u == 0) ? `SBTC_MODE_SPECIAL_TRIG : 4'hA;
        compareBMode <= (u == 1) ? `SBTC_MODE_SPECIAL_TRIG : 4'hA;
        wr(`SBTC_ADDR_CONTROL, (m == 1) ? 8'h03 : 8'h01);
        if (u == 2) begin
          waitFor(16'h0011, 800);
        end else begin
          repeat (2) begin
            waitFor(16'h0010, 800);
            waitFor(16'h0000, 6);
          end
        end
        rdChk(`SBTC_ADDR_FLAG, 32'h0000_0000);
      end
    end
    wr(`SBTC_ADDR_CONTROL, 8'h00);
    wr(`SBTC_ADDR_COUNT_HIGH, 8'h12);
    compareBMode <= `SBTC_MODE_SPECIAL_TRIG;
    apb(1'b1, `SBTC_ADDR_COUNT_LOW, 8'h55, 1'b1);
    @(posedge ref_clk);
    check(32'(countValue), 32'h0000_1255);
  endtask
  task automatic wideScenario();
    wr(`SBTC_ADDR_CONTROL, 8'h80);
    wr(`SBTC_ADDR_COUNT_HIGH, 8'h34);
    @(posedge ref_clk);
    check(32'(countValue), 32'h0000_1255);
    wr(`SBTC_ADDR_COUNT_LOW, 8'h56);
    @(posedge ref_clk);
    check(32'(countValue), 32'h0000_3456);
    wr(`SBTC_ADDR_COUNT_HIGH, 8'h00);
    wr(`SBTC_ADDR_COUNT_LOW, 8'hFF);
    wr(`SBTC_ADDR_CONTROL, 8'hB1);
    rdChk(`SBTC_ADDR_COUNT_LOW, 32'h0000_00FF);
    repeat (300) @(posedge ref_clk);
    rdChk(`SBTC_ADDR_COUNT_HIGH, 32'h0000_0000);
    check(32'(countValue[15:8]), 32'h0000_0001);
  endtask
  task automatic asyncScenario();
    pinRun      <= 1'b0;
    useXtal     <= 1'b1;
    manualEn    <= 1'b1;
    manualLevel <= 1'b1;
    wr(`SBTC_ADDR_CONTROL, 8'h0F);
    manualLevel <= 1'b0;
    repeat (10) @(posedge ref_clk);
    wr(`SBTC_ADDR_COUNT_HIGH, 8'h01);
    wr(`SBTC_ADDR_COUNT_LOW, 8'h00);
    for (int k = 0; k < 2; k++) begin
      manualLevel <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check(32'(countValue), 32'h0000_0100 + 32'(k));
      manualLevel <= 1'b0;
      repeat (10) @(posedge ref_clk);
    end
    wr(`SBTC_ADDR_ENABLE, 8'h01);
    wr(`SBTC_ADDR_COUNT_HIGH, 8'h81);
    manualLevel <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(32'(countValue), 32'h0000_8101);
    apb(1'b0, `SBTC_ADDR_COUNT_LOW, 8'h00, 1'b1);
    check(32'(countValue), 32'h0000_8101);
    manualLevel <= 1'b0;
    repeat (10) @(posedge ref_clk);
    manualLevel <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(32'(countValue), 32'h0000_8102);
  endtask

  // ============================================================
  // verdict
  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    errorCnt++;
    finishTest();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {sysClkFromCrystal, compareAMode, compareBMode} = '0;
    {pinRun, useXtal, manualEn, manualLevel, pulseB} = '0;
    cmpValue = 16'h0010;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    regScenario();
    prescaleScenario();
    overflowScenario();
    trigScenario();
    wideScenario();
    asyncScenario();
    finishTest();
  end
endmodule
